/* File: rtl/nibble_alu.v */
/*
 Combinational 4-bit immediate ALU. Assumes operands valid when used.
*/
`timescale 1ns/10ps
`include "nibble_exec_defines.vh"
module nibble_alu (
   input wire [`OP_W-1:0] opcode_i,
   input wire [3:0] reg_i,
   input wire [3:0] imm_i,
   input wire carry_i,
   output reg [3:0] result_o,
   output reg carry_o,
   output reg carry_we_o
);
   reg [4:0] sum;
   always @* begin
      sum = 5'h00;
      result_o = 4'h0;
      carry_o = carry_i;
      carry_we_o = 1'b0;
      case (opcode_i)
         `OP_ADD_IMM: begin
            sum = {1'b0, reg_i} + {1'b0, imm_i};
            carry_we_o = 1'b1;
         end
         `OP_ADD_IMM_KEEP_FLAG: begin
            sum = {1'b0, reg_i} + {1'b0, imm_i};
         end
         `OP_ADD_IMM_WITH_CARRY: begin
            sum = {1'b0, reg_i} + {1'b0, imm_i} + {4'h0, carry_i};
            carry_we_o = 1'b1;
         end
         `OP_SUB_IMM_WITH_BORROW: begin
            sum = {1'b0, reg_i} + {1'b0, ~imm_i} + {4'h0, carry_i};
            carry_we_o = 1'b1;
         end
         `OP_SUB_IMM: begin
            sum = {1'b0, reg_i} + {1'b0, ~imm_i} + 5'h01;
            carry_we_o = 1'b1;
         end
         `OP_AND_IMM: sum = {1'b0, reg_i & imm_i};
         `OP_XOR_IMM: sum = {1'b0, reg_i ^ imm_i};
         `OP_OR_IMM: sum = {1'b0, reg_i | imm_i};
         default: sum = 5'h00;
      endcase
      result_o = sum[3:0];
      if (carry_we_o)
         carry_o = sum[4];
   end
endmodule // nibble_alu

/* File: rtl/nibble_cpu_exec_unit.v */
/*
 Execution unit for immediate ALU, load/store, table and counter reads,
 halt and stop. Assumes the sequencer issues one instruction per exec
 pulse while busy_o is low, and that memory/ROM read data is combinational
 from the addresses given. Stop gating of the real oscillator is outside;
 here stop freezes all state updates except the pin synchroniser and pin history until release.
*/
`timescale 1ns/10ps
`include "nibble_exec_defines.vh"
module nibble_cpu_exec_unit #(
   parameter MEM_AW = 7,
   parameter TAB_AW = 11
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire exec_i,
   input wire [`OP_W-1:0] opcode_i,
   input wire starred_i,
   input wire hash_i,
   input wire indirect_i,
   input wire [3:0] imm_i,
   input wire [7:0] operand8_i,
   input wire [MEM_AW-1:0] direct_addr_i,
   input wire [3:0] work_reg_operand_i,
   input wire [3:0] mem_rdata_i,
   input wire [7:0] table_rdata_i,
   input wire [15:0] resistance_freq_counter_i,
   input wire [MEM_AW-1:0] index_load_i,
   input wire index_load_en_i,
   input wire irq_accept_i,
   input wire return_i,
   input wire timer1_uflow_i,
   input wire timer2_uflow_i,
   input wire prescale_ovf_i,
   input wire counter_ovf_i,
   input wire [3:0] port_c_lines_i,
   input wire [3:0] port_d_lines_i,
   input wire ext_pin_i,
   input wire key_scan_hit_i,
   output reg [3:0] work_nibble_reg_o,
   output reg carry_bit_o,
   output reg [MEM_AW-1:0] index_pointer_o,
   output reg [MEM_AW-1:0] mem_addr_o,
   output reg [3:0] mem_wdata_o,
   output reg mem_we_o,
   output reg work_reg_we_o,
   output reg [3:0] work_reg_wdata_o,
   output reg [TAB_AW-1:0] table_addr_o,
   output reg halted_o,
   output reg stopped_o,
   output reg busy_o
);
   wire [3:0] alu_result;
   wire alu_carry;
   wire alu_carry_we;
   wire [9:0] pins_sync;
   wire [3:0] port_c_s;
   wire [3:0] port_d_s;
   wire pin_s;
   wire key_s;
   reg [3:0] port_c_prev_ff;
   reg [3:0] port_d_prev_ff;
   reg pin_prev_ff;
   reg [7:0] wake_sel_ff;
   reg [7:0] halt_en_ff;
   reg [7:0] stop_en_ff;
   reg halt_ff;
   reg in_service_ff;
   reg stop_ff;
   reg [3:0] work_ff;
   reg carry_ff;
   reg [MEM_AW-1:0] index_ff;
   reg [MEM_AW-1:0] nxt_index;
   reg [3:0] nxt_work;
   reg nxt_carry;
   reg [3:0] nxt_mem_wdata;
   reg nxt_mem_we;
   reg nxt_reg_we;
   reg [MEM_AW-1:0] nxt_mem_addr;
   reg inc_index;
   reg halt_wake;
   reg stop_wake;
   wire port_c_change;
   wire port_d_change;
   wire pin_change;

   nibble_alu u_alu (
      .opcode_i(opcode_i),
      .reg_i(work_reg_operand_i),
      .imm_i(imm_i),
      .carry_i(carry_ff),
      .result_o(alu_result),
      .carry_o(alu_carry),
      .carry_we_o(alu_carry_we)
   );

   sync2 #(.W(10)) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({key_scan_hit_i, ext_pin_i, port_d_lines_i, port_c_lines_i}),
      .sync_o(pins_sync)
   );
   assign port_c_s = pins_sync[3:0];
   assign port_d_s = pins_sync[7:4];
   assign pin_s = pins_sync[8];
   assign key_s = pins_sync[9];
   assign port_c_change = |(port_c_s ^ port_c_prev_ff);
   assign port_d_change = |(port_d_s ^ port_d_prev_ff);
   assign pin_change = pin_s ^ pin_prev_ff;

   // Pin history keeps running in stop so edges are seen for release
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         port_c_prev_ff <= 4'h0;
         port_d_prev_ff <= 4'h0;
         pin_prev_ff <= 1'b0;
      end else begin
         port_c_prev_ff <= port_c_s;
         port_d_prev_ff <= port_d_s;
         pin_prev_ff <= pin_s;
      end
   end

   // Release conditions
   always @* begin
      halt_wake = irq_accept_i
         | (wake_sel_ff[`WAKE_PORT_C_BIT] & port_c_change)
         | (halt_en_ff[`HEN_TIMER1_BIT] & timer1_uflow_i)
         | (halt_en_ff[`HEN_PIN_BIT] & pin_change)
         | (halt_en_ff[`HEN_PRESCALE_BIT] & prescale_ovf_i)
         | (halt_en_ff[`HEN_TIMER2_BIT] & timer2_uflow_i)
         | (halt_en_ff[`HEN_COUNTER_BIT] & counter_ovf_i);
   end

   // Stop exits on key level, pin change or any port C high
   always @* begin
      stop_wake = key_s | pin_change | (|port_c_s)
         | (stop_en_ff[`SEN_PORT_D_BIT] & port_d_change)
         | (stop_en_ff[`SEN_PORT_C_BIT] & port_c_change)
         | (stop_en_ff[`SEN_PIN_BIT] & pin_change);
   end

   // Instruction decode; indirect or-store, store and load-memory forms address through the index pointer
   always @* begin
      nxt_work = work_ff;
      nxt_carry = carry_ff;
      nxt_mem_we = 1'b0;
      nxt_reg_we = 1'b0;
      nxt_mem_wdata = 4'h0;
      nxt_mem_addr = indirect_i ? index_ff : direct_addr_i;
      inc_index = 1'b0;
      case (opcode_i)
         `OP_ADD_IMM, `OP_ADD_IMM_KEEP_FLAG, `OP_ADD_IMM_WITH_CARRY,
         `OP_SUB_IMM_WITH_BORROW, `OP_SUB_IMM, `OP_AND_IMM, `OP_XOR_IMM,
         `OP_OR_IMM: begin
            nxt_work = alu_result;
            nxt_carry = alu_carry_we ? alu_carry : carry_ff;
            nxt_reg_we = starred_i;
         end
         `OP_OR_STORE: begin
            nxt_work = work_ff | mem_rdata_i;
            nxt_mem_wdata = work_ff | mem_rdata_i;
            nxt_mem_we = 1'b1;
            inc_index = hash_i;
         end
         `OP_STORE_WORK: begin
            nxt_mem_wdata = work_ff;
            nxt_mem_we = 1'b1;
            inc_index = hash_i;
         end
         `OP_LOAD_IMM: begin
            nxt_mem_addr = direct_addr_i;
            nxt_work = imm_i;
            nxt_mem_wdata = imm_i;
            nxt_mem_we = 1'b1;
         end
         `OP_LOAD_MEM: begin
            nxt_work = mem_rdata_i;
            inc_index = hash_i;
         end
         `OP_TABLE_HIGH_READ, `OP_TABLE_LOW_READ: begin
            nxt_mem_addr = direct_addr_i;
            nxt_work = (opcode_i == `OP_TABLE_HIGH_READ) ?
               table_rdata_i[7:4] : table_rdata_i[3:0];
            nxt_mem_wdata = nxt_work;
            nxt_mem_we = 1'b1;
            inc_index = starred_i;
         end
         `OP_COUNTER_NIBBLE0_READ, `OP_COUNTER_NIBBLE1_READ,
         `OP_COUNTER_NIBBLE2_READ, `OP_COUNTER_NIBBLE3_READ: begin
            nxt_mem_addr = direct_addr_i;
            case (opcode_i)
               `OP_COUNTER_NIBBLE0_READ: nxt_work = resistance_freq_counter_i[3:0];
               `OP_COUNTER_NIBBLE1_READ: nxt_work = resistance_freq_counter_i[7:4];
               `OP_COUNTER_NIBBLE2_READ: nxt_work = resistance_freq_counter_i[11:8];
               default: nxt_work = resistance_freq_counter_i[15:12];
            endcase
            nxt_mem_wdata = nxt_work;
            nxt_mem_we = 1'b1;
         end
         default: begin
            nxt_work = work_ff;
         end
      endcase
      nxt_index = inc_index ? index_ff + {{(MEM_AW-1){1'b0}}, 1'b1} : index_ff;
   end

   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         work_ff <= `NIB_RST;
         carry_ff <= 1'b0;
         index_ff <= {MEM_AW{1'b0}};
         wake_sel_ff <= `ENABLES_RST;
         halt_en_ff <= `ENABLES_RST;
         stop_en_ff <= `ENABLES_RST;
         halt_ff <= 1'b0;
         in_service_ff <= 1'b0;
         stop_ff <= 1'b0;
         work_nibble_reg_o <= `NIB_RST;
         carry_bit_o <= 1'b0;
         index_pointer_o <= {MEM_AW{1'b0}};
         mem_addr_o <= {MEM_AW{1'b0}};
         mem_wdata_o <= 4'h0;
         mem_we_o <= 1'b0;
         work_reg_we_o <= 1'b0;
         work_reg_wdata_o <= 4'h0;
         halted_o <= 1'b0;
         stopped_o <= 1'b0;
         busy_o <= 1'b0;
      end else begin
         mem_we_o <= 1'b0;
         work_reg_we_o <= 1'b0;
         if (stop_ff) begin
            // Nothing but the wake check runs while stopped
            if (stop_wake) begin
               stop_ff <= 1'b0;
               stopped_o <= 1'b0;
               busy_o <= 1'b0;
            end
         end else begin
            if (halt_ff && halt_wake) begin
               halt_ff <= 1'b0;
               halted_o <= 1'b0;
               busy_o <= 1'b0;
               in_service_ff <= irq_accept_i;
            end else if (in_service_ff && return_i) begin
               in_service_ff <= 1'b0;
               halt_ff <= 1'b1;
               halted_o <= 1'b1;
               busy_o <= 1'b1;
            end
            if (index_load_en_i) begin
               index_ff <= index_load_i;
               index_pointer_o <= index_load_i;
            end
            // Refused while halted; the sequencer watches busy_o
            if (exec_i && !halt_ff) begin
               case (opcode_i)
                  `OP_HALT: begin
                     halt_ff <= 1'b1;
                     halted_o <= 1'b1;
                     busy_o <= 1'b1;
                  end
                  `OP_STOP: begin
                     // Port C should already be low, else release is immediate
                     stop_ff <= 1'b1;
                     stopped_o <= 1'b1;
                     busy_o <= 1'b1;
                  end
                  `OP_SET_WAKE_SELECT: wake_sel_ff <= operand8_i;
                  `OP_SET_HALT_ENABLE: halt_en_ff <= operand8_i;
                  `OP_SET_STOP_ENABLE: stop_en_ff <= operand8_i;
                  default: begin
                     work_ff <= nxt_work;
                     carry_ff <= nxt_carry;
                     work_nibble_reg_o <= nxt_work;
                     carry_bit_o <= nxt_carry;
                     mem_addr_o <= nxt_mem_addr;
                     mem_wdata_o <= nxt_mem_wdata;
                     mem_we_o <= nxt_mem_we;
                     work_reg_we_o <= nxt_reg_we;
                     work_reg_wdata_o <= nxt_work;
                     // Index load wins over auto-increment
                     if (!index_load_en_i) begin
                        index_ff <= nxt_index;
                        index_pointer_o <= nxt_index;
                     end
                  end
               endcase
            end
         end
      end
   end

   // Table ROM address trails the index by one cycle; frozen in stop
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         table_addr_o <= {TAB_AW{1'b0}};
      end else if (!stop_ff) begin
         table_addr_o <= {{(TAB_AW-MEM_AW){1'b0}}, index_ff};
      end
   end
endmodule // nibble_cpu_exec_unit

/* File: rtl/nibble_exec_defines.vh */
/*
 Constants for the nibble execution unit: opcodes, operand bit positions,
 widths and reset values. Assumes inclusion by bare name from rtl/ files.
*/
`ifndef NIBBLE_EXEC_DEFINES_VH
`define NIBBLE_EXEC_DEFINES_VH
`define OP_W 5
`define OP_NOP 5'h00
`define OP_ADD_IMM 5'h01
`define OP_ADD_IMM_KEEP_FLAG 5'h02
`define OP_ADD_IMM_WITH_CARRY 5'h03
`define OP_SUB_IMM_WITH_BORROW 5'h04
`define OP_SUB_IMM 5'h05
`define OP_AND_IMM 5'h06
`define OP_XOR_IMM 5'h07
`define OP_OR_IMM 5'h08
`define OP_OR_STORE 5'h09
`define OP_STORE_WORK 5'h0a
`define OP_LOAD_IMM 5'h0b
`define OP_LOAD_MEM 5'h0c
`define OP_TABLE_HIGH_READ 5'h0d
`define OP_TABLE_LOW_READ 5'h0e
`define OP_COUNTER_NIBBLE0_READ 5'h0f
`define OP_COUNTER_NIBBLE1_READ 5'h10
`define OP_COUNTER_NIBBLE2_READ 5'h11
`define OP_COUNTER_NIBBLE3_READ 5'h12
`define OP_HALT 5'h13
`define OP_STOP 5'h14
`define OP_SET_WAKE_SELECT 5'h15
`define OP_SET_HALT_ENABLE 5'h16
`define OP_SET_STOP_ENABLE 5'h17
`define WAKE_PORT_C_BIT 4
`define HEN_TIMER1_BIT 1
`define HEN_PIN_BIT 2
`define HEN_PRESCALE_BIT 3
`define HEN_TIMER2_BIT 4
`define HEN_COUNTER_BIT 6
`define SEN_PORT_D_BIT 3
`define SEN_PORT_C_BIT 4
`define SEN_PIN_BIT 5
`define NIB_RST 4'h0
`define ENABLES_RST 8'h00
`endif

/* File: rtl/sync2.v */
/*
 Two-flop synchroniser, parameter width. Assumes asynchronous input levels.
*/
`timescale 1ns/10ps
module sync2 #(
   parameter W = 1
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire [W-1:0] async_i,
   output wire [W-1:0] sync_o
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   always @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end
   assign sync_o = sync_ff;
endmodule // sync2

/* File: tb/nibble_exec_props.sv */
/* Checker for the nibble execution unit, bound to each instance.
 Assumes one clock and results one cycle after the taking edge. */
`timescale 1ns/10ps
`include "nibble_exec_defines.vh"
module nibble_exec_props #(
   parameter MEM_AW = 7,
   parameter TAB_AW = 11
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire exec_i,
   input wire [`OP_W-1:0] opcode_i,
   input wire starred_i,
   input wire hash_i,
   input wire [3:0] imm_i,
   input wire [MEM_AW-1:0] direct_addr_i,
   input wire [3:0] work_reg_operand_i,
   input wire [3:0] mem_rdata_i,
   input wire index_load_en_i,
   input wire [3:0] work_nibble_reg_o,
   input wire carry_bit_o,
   input wire [MEM_AW-1:0] index_pointer_o,
   input wire [MEM_AW-1:0] mem_addr_o,
   input wire [3:0] mem_wdata_o,
   input wire mem_we_o,
   input wire work_reg_we_o,
   input wire [3:0] work_reg_wdata_o,
   input wire halted_o,
   input wire stopped_o
);
   // Refused requests must not arm any check
   wire go = exec_i & ~halted_o & ~stopped_o;
   wire alu = opcode_i >= `OP_ADD_IMM && opcode_i <= `OP_OR_IMM;
   wire hop = opcode_i == `OP_OR_STORE || opcode_i == `OP_STORE_WORK
      || opcode_i == `OP_LOAD_MEM;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   add_sum_a: assert property (go && opcode_i == `OP_ADD_IMM
      |=> {carry_bit_o, work_nibble_reg_o} == {1'b0, $past(work_reg_operand_i)} + $past(imm_i))
      else $error("add result wrong");
   keep_flag_a: assert property (go && opcode_i == `OP_ADD_IMM_KEEP_FLAG
      |=> $stable(carry_bit_o)) else $error("keep-flag add moved carry");
   borrow_sum_a: assert property (go && opcode_i == `OP_SUB_IMM_WITH_BORROW
      |=> {carry_bit_o, work_nibble_reg_o} == {1'b0, $past(work_reg_operand_i)}
      + {1'b0, ~$past(imm_i)} + $past(carry_bit_o)) else $error("borrow result wrong");
   logic_carry_a: assert property (go && opcode_i >= `OP_AND_IMM && alu
      |=> $stable(carry_bit_o)) else $error("logic op moved carry");
   star_write_a: assert property (go && alu && starred_i
      |=> work_reg_we_o && work_reg_wdata_o == work_nibble_reg_o)
      else $error("starred form missed register write");
   or_store_a: assert property (go && opcode_i == `OP_OR_STORE
      |=> work_nibble_reg_o == ($past(work_nibble_reg_o) | $past(mem_rdata_i))
      && mem_we_o && mem_wdata_o == work_nibble_reg_o) else $error("or-store wrong");
   hash_incr_a: assert property (go && hash_i && hop && !index_load_en_i
      |=> index_pointer_o == $past(index_pointer_o) + 1'b1) else $error("index not bumped");
   load_imm_a: assert property (go && opcode_i == `OP_LOAD_IMM
      |=> work_nibble_reg_o == $past(imm_i) && mem_we_o && mem_wdata_o == $past(imm_i)
      && mem_addr_o == $past(direct_addr_i)) else $error("load immediate wrong");
   nop_still_a: assert property (go && opcode_i == `OP_NOP && !index_load_en_i
      |=> $stable(work_nibble_reg_o) && $stable(carry_bit_o) && $stable(index_pointer_o)
      && !mem_we_o && !work_reg_we_o) else $error("nop changed state");
   halt_enter_a: assert property (go && opcode_i == `OP_HALT |=> halted_o)
      else $error("halt not entered");
   stop_freeze_a: assert property (stopped_o && $past(stopped_o)
      |-> $stable(work_nibble_reg_o) && !mem_we_o) else $error("activity in stop");
   cover property ($fell(halted_o));
   cover property ($fell(stopped_o));
   cover property (go && alu && starred_i);
endmodule // nibble_exec_props

bind nibble_cpu_exec_unit nibble_exec_props #(.MEM_AW(MEM_AW), .TAB_AW(TAB_AW)) u_props (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .exec_i(exec_i), .opcode_i(opcode_i),
   .starred_i(starred_i), .hash_i(hash_i), .imm_i(imm_i), .direct_addr_i(direct_addr_i),
   .work_reg_operand_i(work_reg_operand_i), .mem_rdata_i(mem_rdata_i),
   .index_load_en_i(index_load_en_i), .work_nibble_reg_o(work_nibble_reg_o),
   .carry_bit_o(carry_bit_o), .index_pointer_o(index_pointer_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o), .work_reg_we_o(work_reg_we_o),
   .work_reg_wdata_o(work_reg_wdata_o), .halted_o(halted_o), .stopped_o(stopped_o));

/* File: tb/tb_top.sv */
/* Bench for the nibble execution unit: ALU, memory, table, counter, halt, stop.
 Assumes combinational memory and table data, modelled here. */
`timescale 1ns/10ps
`include "nibble_exec_defines.vh"
module tb_top;
   reg clk_sys_i = 1'b0;
   reg rst_i = 1'b1;
   reg ex = 0, st = 0, hs = 0, ind = 0, ld = 0, irq = 0, ret = 0;
   reg t1 = 0, t2 = 0, pre = 0, ovf = 0, pin = 0, key = 0;
   reg [4:0] op = 0;
   reg [3:0] imm = 0, wreg = 0, pc = 0, pd = 0;
   reg [7:0] x8 = 0;
   reg [6:0] da = 0, li = 0;
   reg [15:0] cnt = 16'h4c2e;
   reg [3:0] mem [0:127];
   reg [4:0] r;
   reg c_exp = 0;
   integer n_fail = 0, tests_run = 0, i, k;
   wire [3:0] work, wd, wrd, mrd;
   wire [6:0] idx, ma;
   wire [10:0] ta;
   wire cy, we, wrwe, halted, stopped, busy;
   // Table contents derived from the address so expectations need no copy
   wire [7:0] rom = {ta[3:0] ^ 4'h6, ~ta[3:0]};
   assign mrd = mem[ind ? idx : da];
   always @(posedge clk_sys_i) if (we) mem[ma] <= wd;
   nibble_cpu_exec_unit u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .exec_i(ex),
      .opcode_i(op), .starred_i(st), .hash_i(hs), .indirect_i(ind), .imm_i(imm),
      .operand8_i(x8), .direct_addr_i(da), .work_reg_operand_i(wreg), .mem_rdata_i(mrd),
      .table_rdata_i(rom), .resistance_freq_counter_i(cnt), .index_load_i(li),
      .index_load_en_i(ld), .irq_accept_i(irq), .return_i(ret), .timer1_uflow_i(t1),
      .timer2_uflow_i(t2), .prescale_ovf_i(pre), .counter_ovf_i(ovf), .port_c_lines_i(pc),
      .port_d_lines_i(pd), .ext_pin_i(pin), .key_scan_hit_i(key), .work_nibble_reg_o(work),
      .carry_bit_o(cy), .index_pointer_o(idx), .mem_addr_o(ma), .mem_wdata_o(wd),
      .mem_we_o(we), .work_reg_we_o(wrwe), .work_reg_wdata_o(wrd), .table_addr_o(ta),
      .halted_o(halted), .stopped_o(stopped), .busy_o(busy));
   initial forever #4 clk_sys_i = ~clk_sys_i;
   function [4:0] alu(input [4:0] o, input [3:0] a, input [3:0] b, input c);
      case (o)
         `OP_ADD_IMM: alu = a + b;
         `OP_ADD_IMM_KEEP_FLAG: alu = {c, a + b};
         `OP_ADD_IMM_WITH_CARRY: alu = a + b + c;
         `OP_SUB_IMM_WITH_BORROW: alu = {1'b0, a} + {1'b0, ~b} + c;
         `OP_SUB_IMM: alu = {1'b0, a} + {1'b0, ~b} + 5'h01;
         `OP_AND_IMM: alu = {c, a & b};
         `OP_XOR_IMM: alu = {c, a ^ b};
         default: alu = {c, a | b};
      endcase
   endfunction
   task chk(input [15:0] got, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Leaves exec high so calls run back to back; idle drops it
   task issue(input [4:0] o, input [3:0] d, input s, input h, input n);
      begin
         op = o;
         imm = d;
         st = s;
         hs = h;
         ind = n;
         ex = 1'b1;
         @(negedge clk_sys_i);
      end
   endtask
   task idle;
      begin
         ex = 1'b0;
         @(negedge clk_sys_i);
      end
   endtask
   task wait_rel(input s);
      begin
         k = 0;
         while (k < 20 && (s ? stopped : halted) !== 1'b0) begin
            @(negedge clk_sys_i);
            k = k + 1;
         end
         chk(s ? stopped : halted, 0);
      end
   endtask
   task report_and_stop;
      begin
         if (n_fail == 0 && tests_run > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      #200000;
      n_fail = n_fail + 1;
      report_and_stop;
   end
   initial begin
      for (i = 0; i < 128; i = i + 1) mem[i] = 4'h0;
      repeat (6) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk({work, cy, idx, we, halted, stopped}, 0);
      for (i = 0; i < 48; i = i + 1) begin
         wreg = i[3:0] * 4'h7;
         r = alu(5'h01 + i[2:0], wreg, i[5:2] ^ {4{i[0]}}, c_exp);
         issue(5'h01 + i[2:0], i[5:2] ^ {4{i[0]}}, i[3], 0, 0);
         chk(work, r[3:0]);
         chk(cy, r[4]);
         chk({wrwe, wrd & {4{i[3]}}}, {i[3], r[3:0] & {4{i[3]}}});
         c_exp = r[4];
      end
      da = 7'h0a;
      issue(`OP_LOAD_IMM, 4'ha, 0, 0, 0);
      chk({we, ma, wd, work}, {1'b1, 7'h0a, 4'ha, 4'ha});
      da = 7'h0b;
      issue(`OP_LOAD_IMM, 4'h5, 0, 0, 0);
      idle;
      li = 7'h0a;
      ld = 1'b1;
      @(negedge clk_sys_i);
      ld = 1'b0;
      issue(`OP_LOAD_MEM, 0, 0, 1, 1);
      chk({work, idx, we}, {4'ha, 7'h0b, 1'b0});
      issue(`OP_OR_STORE, 0, 0, 1, 1);
      chk({work, we, ma, wd, idx}, {4'hf, 1'b1, 7'h0b, 4'hf, 7'h0c});
      da = 7'h14;
      issue(`OP_STORE_WORK, 0, 0, 0, 0);
      chk({we, ma, wd}, {1'b1, 7'h14, 4'hf});
      issue(`OP_STORE_WORK, 0, 0, 0, 1);
      chk({we, ma, idx}, {1'b1, 7'h0c, 7'h0c});
      idle;
      issue(`OP_TABLE_HIGH_READ, 0, 1, 0, 0);
      chk({work, we, ma, wd, idx}, {4'ha, 1'b1, 7'h14, 4'ha, 7'h0d});
      idle;
      issue(`OP_TABLE_LOW_READ, 0, 0, 0, 0);
      chk({work, wd, idx}, {4'h2, 4'h2, 7'h0d});
      chk(ta, 11'h00d);
      for (i = 0; i < 4; i = i + 1) begin
         issue(`OP_COUNTER_NIBBLE0_READ + i[4:0], 0, 0, 0, 0);
         chk({work, wd}, {2{cnt[4 * i +: 4]}});
      end
      issue(`OP_NOP, 4'h7, 0, 0, 0);
      chk({work, idx, we}, {4'h4, 7'h0d, 1'b0});
      for (i = 0; i < 5; i = i + 1) begin
         x8 = 8'h01 << (i + 1 + (i == 4));
         issue(`OP_SET_HALT_ENABLE, 0, 0, 0, 0);
         issue(`OP_HALT, 0, 0, 0, 0);
         idle;
         chk({halted, busy}, 2'b11);
         {t1, pre} = {i != 0, i != 2};
         @(negedge clk_sys_i);
         {t1, pre} = 2'b00;
         chk(halted, 1);
         case (i)
            0: t1 = 1'b1;
            1: pin = ~pin;
            2: pre = 1'b1;
            3: t2 = 1'b1;
            default: ovf = 1'b1;
         endcase
         @(negedge clk_sys_i);
         {t1, t2, pre, ovf} = 4'h0;
         wait_rel(0);
      end
      x8 = 8'h10;
      issue(`OP_SET_WAKE_SELECT, 0, 0, 0, 0);
      issue(`OP_HALT, 0, 0, 0, 0);
      da = 7'h1e;
      issue(`OP_LOAD_IMM, 4'h3, 0, 0, 0);
      idle;
      chk({halted, we, work}, {1'b1, 1'b0, 4'h4});
      irq = 1'b1;
      @(negedge clk_sys_i);
      irq = 1'b0;
      wait_rel(0);
      ret = 1'b1;
      @(negedge clk_sys_i);
      ret = 1'b0;
      chk(halted, 1);
      pc = 4'h1;
      wait_rel(0);
      pc = 4'h0;
      x8 = 8'h08;
      issue(`OP_SET_STOP_ENABLE, 0, 0, 0, 0);
      idle;
      repeat (3) @(negedge clk_sys_i);
      for (i = 0; i < 4; i = i + 1) begin
         issue(`OP_STOP, 0, 0, 0, 0);
         issue(`OP_LOAD_IMM, 4'h9, 0, 0, 0);
         idle;
         repeat (2) @(negedge clk_sys_i);
         chk({stopped, busy, we, work}, {3'b110, 4'h4});
         case (i)
            0: pc = 4'h8;
            1: pin = ~pin;
            2: key = 1'b1;
            default: pd = ~pd;
         endcase
         wait_rel(1);
         repeat (2) @(negedge clk_sys_i);
         pc = 4'h0;
         key = 1'b0;
         repeat (4) @(negedge clk_sys_i);
      end
      report_and_stop;
   end
endmodule // tb_top
